/* verilog/empc_ctrl.sv */
// How it works
// - Request high halts at state S2
// - Emulator reads/writes registers, PC, RAM
// - Request low resumes free running
// - Type select low means standard type
// - Type select pulled up: advanced default
// - Strobe and ALE float in emulation
// - ROM-size code sets standard verify width
// - Size bits come from P8.1, P8.0
// - Advanced port 0 is plain I/O
// - Advanced port 2 is plain I/O
// - Ports freeze at emulation entry
// - Standard port 0 floats when deselected
// - Standard port 2 mask floats or keeps pins
// - Memory enable and S1 clock outputs
// - Data port bidirectional when selected
// - Low address driven by emulator
// - High address bit 0 picks target
module empc_ctrl
	import empc_pkg::*;
(
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              reset,
	// Emulator control
	input  wire logic              emulation_request,
	input  wire logic              emulation_access_select_n,
	input  wire logic              emu_write,
	input  wire logic              standard_type_select_n,
	input  wire logic              rom_size_sel_hi,
	input  wire logic              rom_size_sel_lo,
	// Emulation address and data pins
	input  wire logic [W_PORT-1:0] low_address_port,
	input  wire logic [W_PORT-1:0] high_address_port,
	input  wire logic [W_PORT-1:0] low_addr_data_port_in,
	output logic      [W_PORT-1:0] low_addr_data_port_out,
	output logic                   low_addr_data_port_oe,
	// Core-side port values and enables from normal operation
	input  wire logic [W_PORT-1:0] core_p0,
	input  wire logic [W_PORT-1:0] core_p0_oe,
	input  wire logic [W_PORT-1:0] core_p1,
	input  wire logic [W_PORT-1:0] core_p2,
	input  wire logic [W_PORT-1:0] core_p2_oe,
	input  wire logic [W_PORT-1:0] core_ext_addr_lo,
	input  wire logic [W_PORT-1:0] core_ext_addr_hi,
	input  wire logic              core_ext_access,
	input  wire logic              core_program_store_strobe_n_n,
	input  wire logic              core_ale,
	input  wire logic              core_code_internal,
	// Port pins
	output logic      [W_PORT-1:0] port0_out,
	output logic      [W_PORT-1:0] port0_oe,
	output logic      [W_PORT-1:0] port1_out,
	output logic      [W_PORT-1:0] port2_out,
	output logic      [W_PORT-1:0] port2_oe,
	// Strobes
	output logic                   program_store_strobe_n,
	output logic                   program_store_strobe_oe,
	output logic                   ale_out,
	output logic                   ale_oe,
	// Status to emulator and core
	output logic                   internal_program_memory_en,
	output logic                   state1_timing_clock,
	output logic                   core_clock_enable,
	output logic                   standard_type,
	output logic      [W_ROM_SEL-1:0] rom_size,
	output logic      [15:0]       program_counter,
	output logic      [W_PORT-1:0] port2_float_mask
);
	////////////////////////////////////////////////////////////////////////////////
	// Synchronisers
	logic req_s1, req_s2, sel_s1, sel_n, typ_s1, typ_n;
	logic [W_ROM_SEL-1:0] rom_s1, rom_s2;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			sel_s1 <= 1'b1;
			sel_n  <= 1'b1;
		end else begin
			req_s1 <= emulation_request;
			req_s2 <= req_s1;
			sel_s1 <= emulation_access_select_n;
			sel_n  <= sel_s1;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			typ_s1 <= 1'b1;
			typ_n  <= 1'b1;
			rom_s1 <= ROM_4K;
			rom_s2 <= ROM_4K;
		end else begin
			typ_s1 <= standard_type_select_n;
			typ_n  <= typ_s1;
			// hi from P8.1, lo from P8.0
			rom_s1 <= {rom_size_sel_hi, rom_size_sel_lo};
			rom_s2 <= rom_s1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Machine state and emulation mode
	logic [W_STATE-1:0] mstate;
	empc_mode_e         mode;
	logic               halted;

	assign halted = (mode == EMPC_HALT);

	// Machine state sequencer, held while halted
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			mstate <= ST_S1;
		end else if (!halted) begin
			mstate <= (mstate == ST_LAST) ? ST_S1 : mstate + 3'h1;
		end
	end

	// halt at S2 of next instruction
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			mode <= EMPC_RUN;
		end else begin
			case (mode)
				EMPC_RUN: begin
					if (req_s2) begin
						mode <= EMPC_WAIT_S2;
					end
				end
				// Halt on the S1 edge, so the sequencer holds S2
				EMPC_WAIT_S2: begin
					if (!req_s2) begin
						mode <= EMPC_RUN;
					end else if (mstate == ST_S1) begin
						mode <= EMPC_HALT;
					end
				end
				EMPC_HALT: begin
					if (!req_s2) begin
						mode <= EMPC_RUN;
					end
				end
				default: mode <= EMPC_RUN;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Emulator access path
	logic sel_act, acc_wr, tgt_ram;
	logic [W_PORT-1:0] ram_rd;
	logic [W_PORT-1:0] sfr_mem_rd;
	logic [W_PORT-1:0] next_rd;
	logic              next_spec;

	assign sel_act = halted && !sel_n;
	// bit 0 chooses RAM or SFR/PC
	assign tgt_ram = (high_address_port[0] == TGT_RAM);
	assign acc_wr  = sel_act && emu_write;

	empc_ram u_ram (
		.mclk    (mclk),
		.wr_en   (acc_wr && tgt_ram),
		.addr    (low_address_port),
		.wr_data (low_addr_data_port_in),
		.rd_data (ram_rd)
	);

	empc_ram u_sfr (
		.mclk    (mclk),
		.wr_en   (acc_wr && !tgt_ram),
		.addr    (low_address_port),
		.wr_data (low_addr_data_port_in),
		.rd_data (sfr_mem_rd)
	);

	// program counter and port 2 mask
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			program_counter  <= RST_PC;
			port2_float_mask <= RST_BYTE;
		end else if (acc_wr && !tgt_ram) begin
			case (low_address_port)
				ADDR_PC_LO: program_counter[7:0]  <= low_addr_data_port_in;
				ADDR_PC_HI: program_counter[15:8] <= low_addr_data_port_in;
				ADDR_MP2:   port2_float_mask      <= low_addr_data_port_in;
				default: ;
			endcase
		end
	end

	// Read data mux for register space
	always_comb begin
		next_rd   = RST_BYTE;
		next_spec = 1'b1;
		case (low_address_port)
			ADDR_PC_LO: next_rd = program_counter[7:0];
			ADDR_PC_HI: next_rd = program_counter[15:8];
			ADDR_MP2:   next_rd = port2_float_mask;
			default:    next_spec = 1'b0;
		endcase
	end

	logic tgt_ram_q, spec_q;
	logic [W_PORT-1:0] sfr_rd;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			tgt_ram_q <= 1'b0;
			spec_q    <= 1'b0;
			sfr_rd    <= RST_BYTE;
		end else begin
			tgt_ram_q <= tgt_ram;
			spec_q    <= next_spec;
			sfr_rd    <= next_rd;
		end
	end

	// data port drives only on selected reads
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			low_addr_data_port_out <= RST_BYTE;
			low_addr_data_port_oe  <= 1'b0;
		end else begin
			low_addr_data_port_out <= tgt_ram_q ? ram_rd : (spec_q ? sfr_rd : sfr_mem_rd);
			low_addr_data_port_oe  <= sel_act && !emu_write;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin function selection
	function automatic logic [7:0] hi_mask(input logic [1:0] code);
		case (code)
			ROM_4K:  hi_mask = HI_MASK_4K;
			ROM_8K:  hi_mask = HI_MASK_8K;
			ROM_16K: hi_mask = HI_MASK_16K;
			default: hi_mask = HI_MASK_32K;
		endcase
	endfunction : hi_mask

	logic std, emu, ext_std;
	assign std     = !typ_n;
	assign emu     = (mode != EMPC_RUN);
	assign ext_std = std && core_ext_access;

	// Status outputs and clock gating
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			standard_type              <= 1'b0;
			rom_size                   <= ROM_4K;
			core_clock_enable          <= 1'b0;
			internal_program_memory_en <= 1'b0;
			state1_timing_clock        <= 1'b0;
		end else begin
			standard_type              <= std;
			rom_size                   <= rom_s2;
			core_clock_enable          <= !halted;
			internal_program_memory_en <= core_code_internal;
			state1_timing_clock        <= (mstate == ST_S1) && !halted;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			program_store_strobe_n  <= 1'b1;
			program_store_strobe_oe <= 1'b0;
			ale_out                 <= 1'b0;
			ale_oe                  <= 1'b0;
		end else begin
			program_store_strobe_n  <= core_program_store_strobe_n_n;
			program_store_strobe_oe <= !emu;
			ale_out                 <= core_ale;
			ale_oe                  <= !emu;
		end
	end

	// ports 1, 0, 2 hold at entry
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			port1_out <= RST_PORT;
		end else if (!emu) begin
			port1_out <= core_p1;
		end
	end

	// Port 0: normal, verify bus, or emulation
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			port0_out <= RST_PORT;
			port0_oe  <= RST_BYTE;
		end else if (!emu) begin
			// standard uses port 0 as address/data bus
			// advanced port 0 stays plain I/O
			port0_out <= ext_std ? core_ext_addr_lo : core_p0;
			port0_oe  <= ext_std ? {W_PORT{1'b1}} : core_p0_oe;
		end else if (std && sel_n) begin
			port0_oe  <= RST_BYTE;
		end
	end

	// Port 2: normal, verify high address, or emulation mask
	logic [W_PORT-1:0] p2_oe_hold, next_p2_oe;
	assign next_p2_oe = ext_std ? {W_PORT{1'b1}} : core_p2_oe;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			port2_out  <= RST_PORT;
			port2_oe   <= RST_BYTE;
			p2_oe_hold <= RST_BYTE;
		end else if (!emu) begin
			// high address trimmed to ROM size
			// advanced port 2 stays plain I/O
			port2_out  <= ext_std ? (core_ext_addr_hi & hi_mask(rom_s2)) : core_p2;
			port2_oe   <= next_p2_oe;
			p2_oe_hold <= next_p2_oe;
		end else if (std && sel_n && halted) begin
			// mask bit 1 floats, 0 keeps entry state
			port2_oe   <= p2_oe_hold & ~port2_float_mask;
		end else begin
			port2_oe   <= p2_oe_hold;
		end
	end
endmodule : empc_ctrl

/* include/empc_pkg.sv */
package empc_pkg;
	// Port, ROM select, machine state and RAM address widths
	localparam int W_PORT     = 8;
	localparam int W_ROM_SEL  = 2;
	localparam int W_STATE    = 3;
	localparam int W_RAM_ADDR = 8;
	// Machine states of one instruction cycle (S1..S6)
	localparam logic [2:0] ST_S1   = 3'h1;
	localparam logic [2:0] ST_S2   = 3'h2;
	localparam logic [2:0] ST_S6   = 3'h6;
	localparam logic [2:0] ST_LAST = 3'h6;
	// ROM size codes
	localparam logic [1:0] ROM_4K  = 2'h0;
	localparam logic [1:0] ROM_8K  = 2'h1;
	localparam logic [1:0] ROM_16K = 2'h2;
	localparam logic [1:0] ROM_32K = 2'h3;
	// Verify address limits (highest address bit used) per ROM size
	localparam logic [7:0] HI_MASK_4K  = 8'h0f;
	localparam logic [7:0] HI_MASK_8K  = 8'h1f;
	localparam logic [7:0] HI_MASK_16K = 8'h3f;
	localparam logic [7:0] HI_MASK_32K = 8'h7f;
	// Target select value on high address bit 0
	localparam logic       TGT_SFR_PC = 1'b0;
	localparam logic       TGT_RAM    = 1'b1;
	// Special target addresses inside the register space
	localparam logic [7:0] ADDR_PC_LO = 8'h00;
	localparam logic [7:0] ADDR_PC_HI = 8'h01;
	localparam logic [7:0] ADDR_MP2   = 8'h02;
	// Reset values
	localparam logic [7:0] RST_BYTE   = 8'h00;
	localparam logic [7:0] RST_PORT   = 8'hff;
	localparam logic [15:0] RST_PC    = 16'h0000;
	typedef enum logic [1:0] {
		EMPC_RUN,
		EMPC_WAIT_S2,
		EMPC_HALT
	} empc_mode_e;
endpackage : empc_pkg

/* verilog/empc_ram.sv */
module empc_ram
	import empc_pkg::*;
(
	// Clock
	input  wire logic                  mclk,
	// Access
	input  wire logic                  wr_en,
	input  wire logic [W_RAM_ADDR-1:0] addr,
	input  wire logic [W_PORT-1:0]     wr_data,
	output logic      [W_PORT-1:0]     rd_data
);
	logic [W_PORT-1:0] mem [0:(1<<W_RAM_ADDR)-1];

	// Write port
	always_ff @(posedge mclk) begin
		if (wr_en) begin
			mem[addr] <= wr_data;
		end
	end

	// Registered read
	always_ff @(posedge mclk) begin
		rd_data <= mem[addr];
	end
endmodule : empc_ram

/* sim/empc_ctrl_chk.sv */
module empc_ctrl_chk
	import empc_pkg::*;
(
	// Clock and reset
	input wire logic       mclk,
	input wire logic       reset,
	// Emulator pins
	input wire logic       emulation_request,
	input wire logic       emulation_access_select_n,
	// Watched outputs
	input wire logic       core_clock_enable,
	input wire logic       program_store_strobe_oe,
	input wire logic       ale_oe,
	input wire logic       low_addr_data_port_oe,
	input wire logic       state1_timing_clock,
	input wire logic       standard_type,
	input wire logic [7:0] port0_oe,
	input wire logic [7:0] port1_out,
	input wire logic [7:0] port2_oe,
	input wire logic [7:0] port2_float_mask
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	// Halted, and halted with access deselected
	wire halted = emulation_request && !core_clock_enable;
	wire idle = halted && emulation_access_select_n;
	sequence s_req; $rose(emulation_request) ##1 emulation_request[*8]; endsequence
	sequence s_idle; idle[*4]; endsequence
	property p_halt; s_req |-> ##[0:4] !core_clock_enable; endproperty
	property p_resume; $fell(emulation_request) |-> ##[1:8] core_clock_enable; endproperty
	property p_strobe; halted |-> !program_store_strobe_oe && !ale_oe; endproperty
	property p_p1; halted ##1 halted |-> $stable(port1_out); endproperty
	property p_p0; s_idle ##0 standard_type |-> port0_oe == 8'h00; endproperty
	property p_p2; s_idle ##0 standard_type |-> (port2_oe & port2_float_mask) == 8'h00; endproperty
	property p_dq; s_idle |-> !low_addr_data_port_oe; endproperty
	property p_s1; state1_timing_clock |=> !state1_timing_clock[*4]; endproperty
	a_halt: assert property (p_halt) else $error("no halt after request");
	a_resume: assert property (p_resume) else $error("no resume");
	a_strobe: assert property (p_strobe) else $error("strobe driven in halt");
	a_p1: assert property (p_p1) else $error("port1 moved in halt");
	a_p0: assert property (p_p0) else $error("port0 driven");
	a_p2: assert property (p_p2) else $error("masked port2 driven");
	a_dq: assert property (p_dq) else $error("data port driven");
	a_s1: assert property (p_s1) else $error("s1 clock too often");
endmodule : empc_ctrl_chk
bind empc_ctrl empc_ctrl_chk empc_ctrl_chk_i (.*);

/* sim/empc_emu_model.sv */
module empc_emu_model
	import empc_pkg::*;
(
	// Clock and returned data
	input  wire logic       mclk,
	input  wire logic       low_addr_data_port_oe,
	input  wire logic [7:0] low_addr_data_port_in,
	// Emulator drives
	output logic            emulation_request,
	output logic            emulation_access_select_n,
	output logic            emu_write,
	output logic      [7:0] low_address_port,
	output logic      [7:0] high_address_port,
	output logic      [7:0] dq
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle pins
	initial begin
		{emulation_request, emulation_access_select_n, emu_write} = 3'h2;
		{low_address_port, high_address_port, dq} = 24'h00_0000;
	end
	task automatic request(input logic v);
		@(posedge mclk);
		#1 emulation_request = v;
	endtask : request
	task automatic access(input logic t, input logic [7:0] a, input logic w,
		input logic [7:0] d, output logic [7:0] q, output logic ok);
		int n;
		ok = 1'b0;
		@(posedge mclk);
		#1 emulation_access_select_n = 1'b0;
		{high_address_port, low_address_port, emu_write, dq} = {7'h00, t, a, w, d};
		for (n = 0; n < 12 && !ok; n++) begin
			@(posedge mclk);
			#1 ok = w ? n > 2 : low_addr_data_port_oe === 1'b1;
		end
		@(posedge mclk);
		#1 q = low_addr_data_port_in;
		emulation_access_select_n = 1'b1;
		repeat (3) @(posedge mclk);
		#1 {high_address_port, low_address_port, dq} = ~{high_address_port, low_address_port, dq};
		emu_write = 1'b0;
		repeat (2) @(posedge mclk);
	endtask : access
endmodule : empc_emu_model

/* sim/empc_ctrl_tb.sv */
module empc_ctrl_tb
	import empc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// Design pins
	logic mclk, reset, rom_size_sel_hi, rom_size_sel_lo, type_low, core_ext_access;
	logic core_program_store_strobe_n_n, core_ale, core_code_internal;
	logic [7:0] core_p0, core_p0_oe, core_p1, core_p2, core_p2_oe, core_ext_addr_lo, core_ext_addr_hi;
	wire emulation_request, emulation_access_select_n, emu_write, low_addr_data_port_oe;
	wire program_store_strobe_n, program_store_strobe_oe, ale_out, ale_oe, standard_type;
	wire internal_program_memory_en, state1_timing_clock, core_clock_enable;
	wire [1:0] rom_size;
	wire [15:0] program_counter;
	wire [7:0] low_address_port, high_address_port, low_addr_data_port_out, dq;
	wire [7:0] port0_out, port0_oe, port1_out, port2_out, port2_oe, port2_float_mask;
	// Strap pin with pull-up, low only when driven
	tri1 standard_type_select_n = type_low ? 1'b0 : 1'bz;
	// Shared data wire
	wire [7:0] low_addr_data_port_in = low_addr_data_port_oe ? low_addr_data_port_out : dq;
	int fail_count, compares;
	empc_ctrl empc_ctrl_i (.*);
	empc_emu_model empc_emu_model_i (.*);
	// Clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick
	task automatic end_sim;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	task automatic wait_ce(input logic v);
		for (int n = 0; n < 20 && core_clock_enable !== v; n++) tick(1);
		chk("core_clock_enable", v, core_clock_enable);
		if (core_clock_enable !== v) end_sim();
	endtask : wait_ce
	task automatic acc(input logic t, input logic [7:0] a, input logic w, input logic [7:0] d,
		output logic [7:0] q);
		logic ok;
		empc_emu_model_i.access(t, a, w, d, q, ok);
		chk("handshake", 1'b1, ok);
		if (ok !== 1'b1) end_sim();
	endtask : acc
	////////////////////////////////////////////////////////////////////////////
	task automatic t_adv;
		{core_ext_access, core_code_internal} = 2'h3;
		{core_p0, core_p2, core_ext_addr_lo, core_ext_addr_hi} = 32'h5ac3_a53c;
		tick(6);
		chk("standard_type", 1'b0, standard_type);
		chk("port0_out", 8'h5a, port0_out);
		chk("port2_out", 8'hc3, port2_out);
		chk("internal_program_memory_en", 1'b1, internal_program_memory_en);
		$display("t_adv done");
	endtask : t_adv
	task automatic t_rom;
		logic [7:0] m [4];
		m = '{HI_MASK_4K, HI_MASK_8K, HI_MASK_16K, HI_MASK_32K};
		type_low = 1'b1;
		for (int c = 0; c < 4; c++) begin
			{rom_size_sel_hi, rom_size_sel_lo} = c[1:0];
			tick(6);
			chk("rom_size", c[1:0], rom_size);
			chk("port2_out verify", 8'h3c & m[c], port2_out);
			chk("port0_out verify", 8'ha5, port0_out);
		end
		chk("standard_type", 1'b1, standard_type);
		$display("t_rom done");
	endtask : t_rom
	task automatic t_emul;
		logic [7:0] q;
		core_p1 = 8'h69;
		tick(3);
		empc_emu_model_i.request(1'b1);
		wait_ce(1'b0);
		core_p1 = 8'h96;
		tick(3);
		chk("port1_out", 8'h69, port1_out);
		chk("strobe_oe", 1'b0, program_store_strobe_oe);
		chk("ale_oe", 1'b0, ale_oe);
		acc(TGT_SFR_PC, ADDR_MP2, 1'b1, 8'h0f, q);
		acc(TGT_RAM, ADDR_MP2, 1'b1, 8'hb7, q);
		acc(TGT_SFR_PC, ADDR_PC_LO, 1'b1, 8'h34, q);
		acc(TGT_SFR_PC, ADDR_PC_HI, 1'b1, 8'h12, q);
		acc(TGT_RAM, ADDR_MP2, 1'b0, 8'h00, q);
		chk("ram read", 8'hb7, q);
		acc(TGT_SFR_PC, ADDR_PC_LO, 1'b0, 8'h00, q);
		chk("pc read", 8'h34, q);
		chk("program_counter", 16'h1234, program_counter);
		chk("port2_float_mask", 8'h0f, port2_float_mask);
		chk("port0_oe", 8'h00, port0_oe);
		chk("port2_oe float", 8'h00, port2_oe & 8'h0f);
		chk("port2_oe kept", 8'hf0, port2_oe & 8'hf0);
		chk("data_oe", 1'b0, low_addr_data_port_oe);
		acc(TGT_SFR_PC, ADDR_MP2, 1'b1, 8'h00, q);
		chk("port2_oe restored", 8'hff, port2_oe);
		$display("t_emul done");
	endtask : t_emul
	task automatic t_resume;
		empc_emu_model_i.request(1'b0);
		wait_ce(1'b1);
		for (int n = 0; n < 8 && state1_timing_clock !== 1'b1; n++) tick(1);
		chk("state1_timing_clock", 1'b1, state1_timing_clock);
		$display("t_resume done");
	endtask : t_resume
	// Reset, then the scenarios
	initial begin
		{reset, type_low, rom_size_sel_hi, rom_size_sel_lo} = 4'h8;
		{core_ext_access, core_program_store_strobe_n_n, core_ale, core_code_internal} = 4'h2;
		{core_p0, core_p0_oe, core_p1, core_p2} = 32'h00ff_0000;
		{core_p2_oe, core_ext_addr_lo, core_ext_addr_hi} = 24'hff_0000;
		tick(6);
		reset = 1'b0;
		tick(3);
		t_adv();
		t_rom();
		t_emul();
		t_resume();
		end_sim();
	end
endmodule : empc_ctrl_tb
